// *** rtl/pfo_regs.svh ***
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit register port with byte addresses on word boundaries
`ifndef PFO_REGS_SVH
`define PFO_REGS_SVH

`define PFO_ADDR_W        8
`define PFO_DATA_W        32

`define PFO_OFF_CTRL      8'h00
`define PFO_OFF_PERIOD    8'h04
`define PFO_OFF_CH_EN     8'h08
`define PFO_OFF_FS_TMO    8'h0c
`define PFO_OFF_DOUT      8'h10
`define PFO_OFF_EXT       8'h14
`define PFO_OFF_FS_DOUT   8'h18
`define PFO_OFF_FS_EXT    8'h1c
`define PFO_OFF_FS_PCT    8'h20
`define PFO_OFF_STATUS    8'h24
`define PFO_OFF_MASK      8'h28
`define PFO_OFF_STATE     8'h2c
`define PFO_OFF_DUTY0     8'h30

`define PFO_CTRL_FS_EN    0
`define PFO_CTRL_COV_DOUT 1
`define PFO_CTRL_COV_EXT  2
`define PFO_CTRL_COV_PWM  3
`define PFO_CTRL_AUTO     4
`define PFO_CTRL_APPLY    8
`define PFO_CTRL_W        5
`define PFO_CTRL_RST      5'h0e

`define PFO_EV_ENTER      0
`define PFO_EV_EXIT       1
`define PFO_EV_WRAP       2
`define PFO_EV_W          3

`define PFO_PCT_W         7
`define PFO_PCT_FLD       8
`define PFO_PCT_MAX       7'h64
`define PFO_TMO_W         8

`define PFO_CORE_HZ       200000000
`define PFO_MOD_HZ        25000000
`define PFO_DIV           (`PFO_CORE_HZ / `PFO_MOD_HZ)
`define PFO_STEP_MS       100
`define PFO_STEP_TICKS    (`PFO_MOD_HZ / 1000 * `PFO_STEP_MS)

`endif

// *** rtl/pfo_pkg.sv ***
// shared types of the pwm and failsafe block
// assumes pfo_regs.svh is on the include path
`include "pfo_regs.svh"

package pfo_pkg;

    typedef struct packed {
        logic [`PFO_ADDR_W-1:0] addr;
        logic [`PFO_DATA_W-1:0] wdata;
        logic                   we;
        logic                   re;
    } pfo_bus_req_t;

    typedef enum logic [0:0] {
        PFO_RUN  = 1'b0,
        PFO_SAFE = 1'b1
    } pfo_fs_state_t;

endpackage

// *** rtl/pfo_pwm_chan.sv ***
// one pwm channel: compare of shared counter against own duty
// assumes counter and period come from the parent, same clock
`include "pfo_regs.svh"

module pfo_pwm_chan #(
    parameter int PW = 24
) (
    input  wire logic          i_core_clk,
    input  wire logic          i_rst,
    input  wire logic          i_en,
    input  wire logic          i_fs,
    input  wire logic [PW-1:0] i_period,
    input  wire logic [PW-1:0] i_cnt,
    input  wire logic [PW-1:0] i_duty,
    input  wire logic [6:0]    i_fs_pct,
    output logic               o_pwm
);

    wire [PW+6:0] fs_prod;
    wire [PW+6:0] fs_quot;
    wire [PW-1:0] fs_duty;
    wire [PW-1:0] duty_eff;
    wire          run;
    wire          level;

    // failsafe duty as percent of the period, rounded down
    assign fs_prod  = (PW+7)'(i_period) * (PW+7)'(i_fs_pct);
    assign fs_quot  = fs_prod / (PW+7)'(`PFO_PCT_MAX);
    assign fs_duty  = fs_quot[PW-1:0];
    assign duty_eff = i_fs ? fs_duty : i_duty;
    assign run      = (i_fs | i_en) && (i_period != '0);
    // duty 0 never high, duty >= period always high while run (enabled or failsafe, nonzero period)
    assign level    = run && (i_cnt < duty_eff);

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_pwm <= 1'b0;
        end else begin
            o_pwm <= level;
        end
    end

    a_fs_zero_low : assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_fs && i_fs_pct == 7'h00) |=> !o_pwm)
        else $error("failsafe duty of zero percent drove the output high");

endmodule

// *** rtl/pfo_failsafe_pwm.sv ***
// pwm generator with communication-loss failsafe and register port
// assumes one 200 mhz clock, synchronous reset, host activity pulse
// from logic on the same clock
`include "pfo_regs.svh"

module pfo_failsafe_pwm #(
    parameter int PW         = 24,
    parameter int DOUT_W     = 8,
    parameter int EXT_W      = 8,
    parameter int STEP_TICKS = `PFO_STEP_TICKS
) (
    input  wire logic                   i_core_clk,
    input  wire logic                   i_rst,
    input  wire pfo_pkg::pfo_bus_req_t  i_bus,
    output logic [`PFO_DATA_W-1:0]      o_rdata,
    input  wire logic                   i_host_pkt,
    output logic [1:0]                  o_pwm,
    output logic [DOUT_W-1:0]           o_dout,
    output logic [EXT_W-1:0]            o_ext,
    output logic                        o_estop,
    output logic                        o_irq
);

    localparam int N_CH  = 2;
    localparam int DIV   = `PFO_DIV;
    localparam int DIV_W = $clog2(DIV);
    localparam int PRE_W = $clog2(STEP_TICKS);
    localparam int DW    = `PFO_DATA_W;

    function automatic logic hit(input logic [`PFO_ADDR_W-1:0] a,
                                 input logic [`PFO_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // register port decode
    wire [`PFO_ADDR_W-1:0] addr;
    wire [DW-1:0]          wdata;
    wire                   we;
    wire                   re;
    assign addr  = i_bus.addr;
    assign wdata = i_bus.wdata;
    assign we    = i_bus.we;
    assign re    = i_bus.re;

    wire wr_ctrl;
    wire wr_period;
    wire wr_ch_en;
    wire wr_tmo;
    wire wr_dout;
    wire wr_ext;
    wire wr_fs_dout;
    wire wr_fs_ext;
    wire wr_fs_pct;
    wire wr_status;
    wire wr_mask;
    assign wr_ctrl    = we && hit(addr, `PFO_OFF_CTRL);
    assign wr_period  = we && hit(addr, `PFO_OFF_PERIOD);
    assign wr_ch_en   = we && hit(addr, `PFO_OFF_CH_EN);
    assign wr_tmo     = we && hit(addr, `PFO_OFF_FS_TMO);
    assign wr_dout    = we && hit(addr, `PFO_OFF_DOUT);
    assign wr_ext     = we && hit(addr, `PFO_OFF_EXT);
    assign wr_fs_dout = we && hit(addr, `PFO_OFF_FS_DOUT);
    assign wr_fs_ext  = we && hit(addr, `PFO_OFF_FS_EXT);
    assign wr_fs_pct  = we && hit(addr, `PFO_OFF_FS_PCT);
    assign wr_status  = we && hit(addr, `PFO_OFF_STATUS);
    assign wr_mask    = we && hit(addr, `PFO_OFF_MASK);

    // software registers
    logic [`PFO_CTRL_W-1:0] ctrl_r;
    logic [PW-1:0]          per_sh_r;
    logic [PW-1:0]          per_act_r;
    logic [N_CH-1:0]        ch_en_r;
    logic [`PFO_TMO_W-1:0]  tmo_r;
    logic [DOUT_W-1:0]      dout_r;
    logic [EXT_W-1:0]       ext_r;
    logic [DOUT_W-1:0]      fs_dout_r;
    logic [EXT_W-1:0]       fs_ext_r;
    logic [`PFO_EV_W-1:0]   sts_r;
    logic [`PFO_EV_W-1:0]   mask_r;
    logic [`PFO_EV_W-1:0]   sts_nxt;
    logic [PW-1:0]          duty_sh_r  [N_CH];
    logic [PW-1:0]          duty_act_r [N_CH];
    logic [6:0]             pct_r      [N_CH];

    wire fs_en;
    wire cov_dout;
    wire cov_ext;
    wire cov_pwm;
    wire auto_apply_setting;
    assign fs_en              = ctrl_r[`PFO_CTRL_FS_EN];
    assign cov_dout           = ctrl_r[`PFO_CTRL_COV_DOUT];
    assign cov_ext            = ctrl_r[`PFO_CTRL_COV_EXT];
    assign cov_pwm            = ctrl_r[`PFO_CTRL_COV_PWM];
    assign auto_apply_setting = ctrl_r[`PFO_CTRL_AUTO];

    // period and duty settings go live at the period boundary after an apply request
    logic                   pend_r;
    logic                   pend_nxt;
    logic [N_CH-1:0]        wr_duty;
    wire                    any_pwm_wr;
    wire                    apply_req;
    wire                    fs_pwm;
    assign any_pwm_wr = wr_period | (|wr_duty);
    assign apply_req  = (wr_ctrl && wdata[`PFO_CTRL_APPLY])
                      | (auto_apply_setting && any_pwm_wr);

    // 25 mhz module tick
    logic [DIV_W-1:0] div_r;
    wire              tick;
    assign tick = (div_r == DIV_W'(DIV - 1));

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            div_r <= '0;
        end else begin
            div_r <= tick ? '0 : div_r + DIV_W'(1);
        end
    end

    // shared period counter, counts module ticks
    logic [PW-1:0] cnt_r;
    wire           wrap;
    assign wrap = tick && ((per_act_r == '0) || (cnt_r >= per_act_r - PW'(1)));
    assign pend_nxt = apply_req | (pend_r & ~wrap);

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cnt_r <= '0;
        end else if (wrap) begin
            cnt_r <= '0;
        end else if (tick) begin
            cnt_r <= cnt_r + PW'(1);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            pend_r    <= 1'b0;
            per_act_r <= '0;
        end else begin
            pend_r <= pend_nxt;
            if (wrap && pend_r) begin
                per_act_r <= per_sh_r;
            end
        end
    end

    // per-channel duty, enable and failsafe percent
    genvar g;
    generate
        for (g = 0; g < N_CH; g++) begin : g_ch
            wire [6:0] pct_in;
            assign wr_duty[g] = we && hit(addr, `PFO_OFF_DUTY0 + `PFO_ADDR_W'(4 * g));
            assign pct_in = wdata[g*`PFO_PCT_FLD +: 7];

            always_ff @(posedge i_core_clk) begin
                if (i_rst) begin
                    duty_sh_r[g]  <= '0;
                    duty_act_r[g] <= '0;
                    pct_r[g]      <= '0;
                end else begin
                    if (wr_duty[g]) begin
                        duty_sh_r[g] <= wdata[PW-1:0];
                    end
                    if (wrap && pend_r) begin
                        duty_act_r[g] <= duty_sh_r[g];
                    end
                    if (wr_fs_pct) begin
                        pct_r[g] <= (pct_in > `PFO_PCT_MAX) ? `PFO_PCT_MAX : pct_in;
                    end
                end
            end

            pfo_pwm_chan #(
                .PW       (PW)
            ) u_chan (
                .i_core_clk (i_core_clk),
                .i_rst      (i_rst),
                .i_en       (ch_en_r[g]),
                .i_fs       (fs_pwm),
                .i_period   (per_act_r),
                .i_cnt      (cnt_r),
                .i_duty     (duty_act_r[g]),
                .i_fs_pct   (pct_r[g]),
                .o_pwm      (o_pwm[g])
            );
        end
    endgenerate

    // failsafe supervisor: 100 ms steps since last host activity
    pfo_pkg::pfo_fs_state_t state_r;
    pfo_pkg::pfo_fs_state_t state_nxt;
    logic [PRE_W-1:0]       pre_r;
    logic [`PFO_TMO_W-1:0]  step_r;
    wire                    step_end;
    wire [`PFO_TMO_W-1:0]   tmo_eff;
    wire                    expire;
    wire                    safe;
    wire                    ev_enter;
    wire                    ev_exit;

    assign step_end = tick && (pre_r == PRE_W'(STEP_TICKS - 1));
    assign tmo_eff  = (tmo_r == '0) ? `PFO_TMO_W'(1) : tmo_r;
    assign expire   = fs_en && !i_host_pkt && (step_r >= tmo_eff);
    assign safe     = (state_r == pfo_pkg::PFO_SAFE);
    assign fs_pwm   = safe && cov_pwm;

    always_ff @(posedge i_core_clk) begin
        if (i_rst || i_host_pkt) begin
            pre_r  <= '0;
            step_r <= '0;
        end else if (step_end) begin
            pre_r  <= '0;
            step_r <= (step_r == '1) ? step_r : step_r + `PFO_TMO_W'(1);
        end else if (tick) begin
            pre_r <= pre_r + PRE_W'(1);
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            pfo_pkg::PFO_RUN: begin
                if (expire) begin
                    state_nxt = pfo_pkg::PFO_SAFE;
                end
            end
            pfo_pkg::PFO_SAFE: begin
                if (i_host_pkt || !fs_en) begin
                    state_nxt = pfo_pkg::PFO_RUN;
                end
            end
        endcase
    end

    assign ev_enter = !safe && (state_nxt == pfo_pkg::PFO_SAFE);
    assign ev_exit  = safe && (state_nxt == pfo_pkg::PFO_RUN);

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_r <= pfo_pkg::PFO_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // outputs: host values, or preset levels while in failsafe
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_dout  <= '0;
            o_ext   <= '0;
            o_estop <= 1'b0;
        end else begin
            o_dout  <= (safe && cov_dout) ? fs_dout_r : dout_r;
            o_ext   <= (safe && cov_ext) ? fs_ext_r : ext_r;
            o_estop <= safe;
        end
    end

    // software register writes
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ctrl_r    <= `PFO_CTRL_RST;
            per_sh_r  <= '0;
            ch_en_r   <= '0;
            tmo_r     <= `PFO_TMO_W'(1);
            dout_r    <= '0;
            ext_r     <= '0;
            fs_dout_r <= '0;
            fs_ext_r  <= '0;
            mask_r    <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= wdata[`PFO_CTRL_W-1:0];
            end
            if (wr_period) begin
                per_sh_r <= wdata[PW-1:0];
            end
            if (wr_ch_en) begin
                ch_en_r <= wdata[N_CH-1:0];
            end
            if (wr_tmo) begin
                tmo_r <= wdata[`PFO_TMO_W-1:0];
            end
            if (wr_dout) begin
                dout_r <= wdata[DOUT_W-1:0];
            end
            if (wr_ext) begin
                ext_r <= wdata[EXT_W-1:0];
            end
            if (wr_fs_dout) begin
                fs_dout_r <= wdata[DOUT_W-1:0];
            end
            if (wr_fs_ext) begin
                fs_ext_r <= wdata[EXT_W-1:0];
            end
            if (wr_mask) begin
                mask_r <= wdata[`PFO_EV_W-1:0];
            end
        end
    end

    // sticky events, write one to clear, a new event wins
    wire [`PFO_EV_W-1:0] ev;
    wire [`PFO_EV_W-1:0] clr;
    assign ev      = {wrap, ev_exit, ev_enter};
    assign clr     = wr_status ? wdata[`PFO_EV_W-1:0] : '0;
    assign sts_nxt = (sts_r & ~clr) | ev;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sts_r <= '0;
            o_irq <= 1'b0;
        end else begin
            sts_r <= sts_nxt;
            o_irq <= |(sts_nxt & mask_r);
        end
    end

    // read data, one cycle after the read strobe; unmapped reads zero
    wire [DW-1:0] rd_state;
    wire [DW-1:0] rd_pct;
    wire [DW-1:0] rd_duty;
    wire [DW-1:0] rd_w;
    assign rd_state = {16'h0000, step_r, 7'h00, safe};
    assign rd_pct   = {17'h00000, pct_r[1], 1'b0, pct_r[0]};
    assign rd_duty  = ({DW{hit(addr, `PFO_OFF_DUTY0)}} & DW'(duty_sh_r[0]))
                    | ({DW{hit(addr, `PFO_OFF_DUTY0 + 8'h04)}} & DW'(duty_sh_r[1]));
    assign rd_w = ({DW{hit(addr, `PFO_OFF_CTRL)}}    & DW'(ctrl_r))
                | ({DW{hit(addr, `PFO_OFF_PERIOD)}}  & DW'(per_sh_r))
                | ({DW{hit(addr, `PFO_OFF_CH_EN)}}   & DW'(ch_en_r))
                | ({DW{hit(addr, `PFO_OFF_FS_TMO)}}  & DW'(tmo_r))
                | ({DW{hit(addr, `PFO_OFF_DOUT)}}    & DW'(dout_r))
                | ({DW{hit(addr, `PFO_OFF_EXT)}}     & DW'(ext_r))
                | ({DW{hit(addr, `PFO_OFF_FS_DOUT)}} & DW'(fs_dout_r))
                | ({DW{hit(addr, `PFO_OFF_FS_EXT)}}  & DW'(fs_ext_r))
                | ({DW{hit(addr, `PFO_OFF_FS_PCT)}}  & rd_pct)
                | ({DW{hit(addr, `PFO_OFF_STATUS)}}  & DW'(sts_r))
                | ({DW{hit(addr, `PFO_OFF_MASK)}}    & DW'(mask_r))
                | ({DW{hit(addr, `PFO_OFF_STATE)}}   & rd_state)
                | rd_duty;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= re ? rd_w : '0;
        end
    end

    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    sequence s_expire;
        !safe && expire;
    endsequence

    sequence s_host_back;
        safe && i_host_pkt;
    endsequence

    a_tick_rate_div : assert property (tick |=> !tick [*7] ##1 tick)
        else $error("module tick not every eighth core cycle");

    a_wrap_clears_cnt : assert property (wrap |=> cnt_r == '0)
        else $error("shared counter did not restart at period end");

    a_zero_duty_low : assert property
        ((!fs_pwm && duty_act_r[0] == '0) |=> !o_pwm[0])
        else $error("zero duty drove channel high");

    a_full_duty_high : assert property
        ((!fs_pwm && ch_en_r[0] && per_act_r != '0
          && duty_act_r[0] >= per_act_r) |=> o_pwm[0])
        else $error("full duty let channel drop");

    a_disabled_chan_low : assert property
        ((!fs_pwm && !ch_en_r[1]) |=> !o_pwm[1])
        else $error("disabled channel toggled");

    a_fs_entry_seq : assert property (s_expire |=> safe ##1 o_estop)
        else $error("expired timeout did not enter failsafe");

    a_estop_in_safe : assert property (safe |=> o_estop)
        else $error("motion emergency not forced in failsafe");

    a_safe_dout_level : assert property
        ((safe && cov_dout) |=> o_dout == $past(fs_dout_r))
        else $error("digital outputs not at preset level in failsafe");

    a_host_leaves_safe : assert property (s_host_back |=> !safe ##1 !o_estop)
        else $error("host activity did not clear failsafe");

    a_fs_disabled_run : assert property (!fs_en |=> !safe)
        else $error("failsafe active while globally disabled");

endmodule

// *** verification/pfo_host_model.sv ***
// host link model: marks valid host traffic with one-cycle pulses
// assumes the block's core clock; changes only after rising edges
module pfo_host_model (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic       i_talk,
    input  wire logic [7:0] i_gap,
    output logic            o_pkt
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] gap_cnt_r;

    always_ff @(posedge i_core_clk) begin
        if (i_rst || !i_talk) begin
            gap_cnt_r <= 8'h00;
            o_pkt     <= 1'b0;
        end else begin
            // one pulse each gap, silence while not talking
            o_pkt     <= (gap_cnt_r == 8'h00);
            gap_cnt_r <= (gap_cnt_r >= i_gap) ? 8'h00 : gap_cnt_r + 8'h01;
        end
    end
endmodule

// *** verification/testbench.sv ***
// self-checking bench of the pwm generator with failsafe
// assumes rtl/ header and package compiled first; 200 mhz core clock
`include "pfo_regs.svh"

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  i_core_clk;
    logic                  i_rst;
    pfo_pkg::pfo_bus_req_t bus;
    logic [31:0]           rdata;
    logic                  host_pkt;
    logic                  talk;
    logic [7:0]            gap;
    logic [1:0]            pwm;
    logic [7:0]            dout;
    logic [7:0]            ext;
    logic                  estop;
    logic                  irq;
    int                    failures;
    int                    check_count;
    int                    seed;
    int                    per;
    int                    d0;
    int                    d1;
    int                    n;
    int                    h0;
    int                    h1;
    logic [1:0]            en;
    logic [31:0]           rd;

    initial begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end

    pfo_failsafe_pwm #(.PW(24), .DOUT_W(8), .EXT_W(8), .STEP_TICKS(4)) DUT (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_bus      (bus),
        .o_rdata    (rdata),
        .i_host_pkt (host_pkt),
        .o_pwm      (pwm),
        .o_dout     (dout),
        .o_ext      (ext),
        .o_estop    (estop),
        .o_irq      (irq)
    );

    pfo_host_model host (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_talk     (talk),
        .i_gap      (gap),
        .o_pkt      (host_pkt)
    );

    function automatic int fs_duty(input int p, input int pct);
        return p * pct / 100;
    endfunction

    task automatic conclude();
        $display("TB: checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge i_core_clk);
        bus <= '{addr: a, wdata: d, we: 1'b0, re: 1'b0};
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_core_clk);
        bus <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
        @(posedge i_core_clk);
        bus <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b0};
        #1 d = rdata;
    endtask

    // counts high cycles of both channels over a window
    task automatic run(input int cyc, output int c0, output int c1);
        c0 = 0;
        c1 = 0;
        repeat (cyc) begin
            @(posedge i_core_clk);
            #1;
            c0 += (pwm[0] === 1'b1);
            c1 += (pwm[1] === 1'b1);
            `CHK($isunknown(pwm), 1'b0)
        end
    endtask

    task automatic wait_estop(input logic lvl, input int lim, output int k);
        k = 0;
        while (estop !== lvl && k < lim) begin
            @(posedge i_core_clk);
            #1 k++;
        end
        if (k >= lim) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, estop, lvl);
            conclude();
        end
    endtask

    initial begin
        seed = 32'hf9b0;
        i_rst = 1'b1;
        bus = '0;
        talk = 1'b0;
        gap = 8'h08;
        failures = 0;
        check_count = 0;
        repeat (12) @(posedge i_core_clk);
        i_rst <= 1'b0;
        talk <= 1'b1;
        #1;
        `CHK({estop, irq, pwm, dout, ext}, 20'h0)
        rd_reg(`PFO_OFF_CTRL, rd);
        `CHK(rd, 32'h0000000e)
        rd_reg(`PFO_OFF_FS_TMO, rd);
        `CHK(rd, 32'h00000001)
        wr(8'h3c, 32'hffffffff);
        rd_reg(8'h3c, rd);
        `CHK(rd, 32'h0)
        wr(`PFO_OFF_PERIOD, 32'd1250);
        rd_reg(`PFO_OFF_PERIOD, rd);
        `CHK(rd, 32'd1250)
        $display("test registers done");

        // corner 0%/100% first, then random duties; last pass applies automatically
        for (int i = 0; i < 3; i++) begin
            per = 4 + ($unsigned($random(seed)) % 8);
            d0 = (i == 0) ? 0 : $unsigned($random(seed)) % (per + 1);
            d1 = (i == 0) ? per : $unsigned($random(seed)) % (per + 1);
            en = (i == 0) ? 2'b11 : 2'(i);
            if (i == 2) begin
                wr(`PFO_OFF_CTRL, 32'h0000001e);
            end
            wr(`PFO_OFF_PERIOD, 32'(per));
            wr(`PFO_OFF_DUTY0, 32'(d0));
            wr(`PFO_OFF_DUTY0 + 8'h04, 32'(d1));
            wr(`PFO_OFF_CH_EN, {30'h0, en});
            wr(`PFO_OFF_CTRL, (i == 2) ? 32'h0000001e : 32'h0000010e);
            run(per * 24 + 100, h0, h1);
            run(per * 16, h0, h1);
            `CHK(h0, en[0] ? d0 * 16 : 0)
            `CHK(h1, en[1] ? d1 * 16 : 0)
        end
        rd_reg(`PFO_OFF_STATUS, rd);
        `CHK(rd[`PFO_EV_WRAP], 1'b1)
        `CHK(irq, 1'b0)
        $display("test pwm done");

        wr(`PFO_OFF_DOUT, 32'h0f);
        wr(`PFO_OFF_EXT, 32'hf0);
        wr(`PFO_OFF_FS_DOUT, 32'ha5);
        wr(`PFO_OFF_FS_EXT, 32'h3c);
        wr(`PFO_OFF_FS_PCT, 32'h7f32);
        rd_reg(`PFO_OFF_FS_PCT, rd);
        `CHK(rd, 32'h6432)
        wr(`PFO_OFF_MASK, 32'h1);
        wr(`PFO_OFF_STATUS, 32'h7);
        wr(`PFO_OFF_FS_TMO, 32'h3);
        @(posedge i_core_clk);
        talk <= 1'b0;
        repeat (150) @(posedge i_core_clk);
        #1;
        `CHK(estop, 1'b0)
        `CHK(dout, 8'h0f)
        talk <= 1'b1;
        wr(`PFO_OFF_CTRL, 32'h0000000f);
        repeat (200) @(posedge i_core_clk);
        #1;
        `CHK(estop, 1'b0)
        @(posedge i_core_clk);
        talk <= 1'b0;
        wait_estop(1'b1, 200, n);
        `CHK(n >= 56, 1'b1)
        `CHK(n <= 3 * 32 + 8, 1'b1)
        `CHK(dout, 8'ha5)
        `CHK(ext, 8'h3c)
        `CHK(irq, 1'b1)
        rd_reg(`PFO_OFF_STATE, rd);
        `CHK(rd[0], 1'b1)
        repeat (per * 8 + 16) @(posedge i_core_clk);
        run(per * 16, h0, h1);
        `CHK(h0, fs_duty(per, 50) * 16)
        `CHK(h1, fs_duty(per, 100) * 16)
        wr(`PFO_OFF_FS_PCT, 32'h00000032);
        run(per * 8 + 16, h0, h1);
        run(per * 16, h0, h1);
        `CHK(h0, fs_duty(per, 50) * 16)
        `CHK(h1, 0)
        wr(`PFO_OFF_STATUS, 32'h1);
        #1;
        `CHK(irq, 1'b0)
        $display("test failsafe entry done");

        @(posedge i_core_clk);
        talk <= 1'b1;
        wait_estop(1'b0, 40, n);
        repeat (2) @(posedge i_core_clk);
        #1;
        `CHK(dout, 8'h0f)
        `CHK(ext, 8'hf0)
        rd_reg(`PFO_OFF_STATUS, rd);
        `CHK(rd[`PFO_EV_EXIT], 1'b1)
        $display("test failsafe exit done");
        conclude();
    end
endmodule
